// >>> hdl/scd_pkg.sv
// Constants and carrier types for the serial control DAC loader.
// Behaviour
// - One loading cycle moves exactly one twelve-bit word while enable is low.
// - First bit selects output, next three ignored, last eight are DAC data.
// - A falling edge on the load enable starts a new loading cycle.
// - While enable is low, data is sampled on every serial clock rising edge.
// - On enable rising edge only the selected DAC output takes the data.
// - While enable is high the interface is disabled and clocks are ignored.
// - With test input low, output mode follows the last programmed function.
// - With test input high, output mode is forced to normal.
package scd_pkg;
  localparam int WORD_BITS = 12;
  localparam int DATA_BITS = 8;
  localparam int SKIP_BITS = 3;
  localparam int SEL_POS = 11;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'hC;
  localparam logic [7:0] DAC_RESET = 8'h00;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] SYNC_RESET = 2'h3;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load_n;
  } scd_link_t;

  typedef struct packed {
    logic [7:0] dac_a;
    logic [7:0] dac_b;
  } scd_dac_t;
endpackage : scd_pkg

// >>> hdl/scd_sync.sv
// Two-stage synchroniser with edge detection on the synchronised level.
`timescale 1ns/100ps
`default_nettype none
module scd_sync #(
  parameter int W = 3,
  parameter logic [2:0] INIT = 3'h7
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } scd_sync_state_t;

  scd_sync_state_t st_reg;
  scd_sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= {3{INIT[W-1:0]}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.s2;
  assign rise_out = st_reg.s2 & ~st_reg.s3;
  assign fall_out = ~st_reg.s2 & st_reg.s3;
endmodule : scd_sync
`default_nettype wire

// >>> hdl/scd_loader.sv
// Serial loader for the two control DACs and the output mode select.
`timescale 1ns/100ps
`default_nettype none
module scd_loader (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic serial_load_enable_n_in,
  input wire logic test_force_normal_in,
  input wire logic [1:0] programmed_mode_in,
  output logic [7:0] control_dac_out_a_out,
  output logic [7:0] control_dac_out_b_out,
  output logic [1:0] output_mode_out,
  output logic busy_out
);
  typedef enum logic {IDLE, SHIFT} scd_fsm_t;

  typedef struct packed {
    scd_fsm_t fsm;
    logic [scd_pkg::WORD_BITS-1:0] shreg;
    logic [scd_pkg::CNT_W-1:0] cnt;
    scd_pkg::scd_dac_t dac;
    logic [1:0] mode;
    logic [1:0] tfn_sync;
  } scd_state_t;

  scd_state_t st_reg;
  scd_state_t st_next;
  scd_pkg::scd_link_t lvl;
  scd_pkg::scd_link_t rise;
  scd_pkg::scd_link_t fall;

  // Saturates so that an overlong word can never wrap back to a full count.
  function automatic logic [scd_pkg::CNT_W-1:0] count_up(
    input logic [scd_pkg::CNT_W-1:0] cnt
  );
    count_up = cnt;
    if (cnt != '1) begin
      count_up = cnt + 4'h1;
    end
  endfunction : count_up

  function automatic logic word_full(
    input logic [scd_pkg::CNT_W-1:0] cnt
  );
    word_full = (cnt == scd_pkg::CNT_FULL);
  endfunction : word_full

  function automatic logic sel_field(
    input logic [scd_pkg::WORD_BITS-1:0] word
  );
    sel_field = word[scd_pkg::SEL_POS];
  endfunction : sel_field

  // The three bits after the select are never looked at.
  function automatic logic [scd_pkg::DATA_BITS-1:0] dac_field(
    input logic [scd_pkg::WORD_BITS-1:0] word
  );
    dac_field = word[scd_pkg::DATA_BITS-1:0];
  endfunction : dac_field

  // Link pins cross in from the far clock before anything reads them.
  scd_sync #(.W(3), .INIT(3'h7)) u_sync (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in({serial_clk_in, serial_data_in, serial_load_enable_n_in}),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );

  always_comb begin
    st_next = st_reg;
    st_next.tfn_sync = {st_reg.tfn_sync[0], test_force_normal_in};
    // The mode is a level, so it is resampled every cycle.
    if (st_reg.tfn_sync[1]) begin
      st_next.mode = scd_pkg::MODE_NORMAL;
    end else begin
      st_next.mode = programmed_mode_in;
    end
    case (st_reg.fsm)
      IDLE: begin
        // Serial clock edges are ignored while enable is high.
        if (fall.load_n) begin
          st_next.fsm = SHIFT;
          st_next.cnt = '0;
          st_next.shreg = '0;
        end
      end
      SHIFT: begin
        if (rise.load_n) begin
          st_next.fsm = IDLE;
          // A short or long word is dropped rather than half applied.
          if (word_full(st_reg.cnt)) begin
            if (sel_field(st_reg.shreg)) begin
              st_next.dac.dac_b = dac_field(st_reg.shreg);
            end else begin
              st_next.dac.dac_a = dac_field(st_reg.shreg);
            end
          end
        end else if (rise.sclk && !lvl.load_n) begin
          st_next.shreg = {st_reg.shreg[scd_pkg::WORD_BITS-2:0],
                           lvl.sdata};
          st_next.cnt = count_up(st_reg.cnt);
        end
      end
      default: st_next.fsm = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg.fsm <= IDLE;
      st_reg.shreg <= '0;
      st_reg.cnt <= '0;
      st_reg.dac.dac_a <= scd_pkg::DAC_RESET;
      st_reg.dac.dac_b <= scd_pkg::DAC_RESET;
      st_reg.mode <= scd_pkg::MODE_RESET;
      st_reg.tfn_sync <= 2'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign control_dac_out_a_out = st_reg.dac.dac_a;
  assign control_dac_out_b_out = st_reg.dac.dac_b;
  assign output_mode_out = st_reg.mode;
  assign busy_out = (st_reg.fsm == SHIFT);

  // All checks run on the system clock; all but a_force_normal see the link and test pins after both synchroniser stages.
  a_start_on_fall: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == IDLE && fall.load_n)
    |=> (st_reg.fsm == SHIFT && st_reg.cnt == '0))
    else $error("load not started");

  a_start_clears: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == IDLE && fall.load_n)
    |=> (st_reg.shreg == '0 && busy_out))
    else $error("stale bits kept");

  a_idle_ignores_clk: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == IDLE && !fall.load_n)
    |=> ($stable(st_reg.shreg) && $stable(st_reg.cnt) && !busy_out))
    else $error("shift while disabled");

  a_shift_bit: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == SHIFT && rise.sclk && !lvl.load_n)
    |=> (st_reg.shreg[0] == $past(lvl.sdata)))
    else $error("bit not shifted");

  a_shift_order: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == SHIFT && rise.sclk && !lvl.load_n)
    |=> (st_reg.shreg[scd_pkg::WORD_BITS-1:1]
    == $past(st_reg.shreg[scd_pkg::WORD_BITS-2:0])))
    else $error("bits out of order");

  a_count_step: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == SHIFT && rise.sclk && !lvl.load_n
    && st_reg.cnt < scd_pkg::CNT_FULL)
    |=> (st_reg.cnt == $past(st_reg.cnt) + 4'h1))
    else $error("bit not counted");

  a_count_sat: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == SHIFT && rise.sclk && !lvl.load_n && st_reg.cnt == '1)
    |=> (st_reg.cnt == '1))
    else $error("count wrapped");

  a_count_hold: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == SHIFT && !rise.sclk && !rise.load_n)
    |=> ($stable(st_reg.cnt) && $stable(st_reg.shreg)))
    else $error("shift without clock");

  a_update_a: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == SHIFT && rise.load_n && st_reg.cnt == scd_pkg::CNT_FULL
    && !st_reg.shreg[scd_pkg::SEL_POS])
    |=> (control_dac_out_a_out == $past(st_reg.shreg[7:0])
    && $stable(control_dac_out_b_out)))
    else $error("dac a wrong");

  a_update_b: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == SHIFT && rise.load_n && st_reg.cnt == scd_pkg::CNT_FULL
    && st_reg.shreg[scd_pkg::SEL_POS])
    |=> (control_dac_out_b_out == $past(st_reg.shreg[7:0])
    && $stable(control_dac_out_a_out)))
    else $error("dac b wrong");

  a_bad_len_drop: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (rise.load_n && st_reg.cnt != scd_pkg::CNT_FULL)
    |=> ($stable(control_dac_out_a_out) && $stable(control_dac_out_b_out)))
    else $error("bad word applied");

  a_dac_hold: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !(st_reg.fsm == SHIFT && rise.load_n)
    |=> ($stable(control_dac_out_a_out) && $stable(control_dac_out_b_out)))
    else $error("dac moved without load");

  a_load_ends: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (st_reg.fsm == SHIFT && rise.load_n)
    |=> !busy_out)
    else $error("load not closed");

  a_force_normal: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    test_force_normal_in [*3]
    |=> (output_mode_out == scd_pkg::MODE_NORMAL))
    else $error("mode not forced");

  a_force_sync: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    st_reg.tfn_sync[1]
    |=> (output_mode_out == scd_pkg::MODE_NORMAL))
    else $error("forced mode lost");

  a_mode_follows: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !st_reg.tfn_sync[1]
    |=> (output_mode_out == $past(programmed_mode_in)))
    else $error("mode not programmed");
endmodule : scd_loader
`default_nettype wire

// >>> sim/scd_ctrl_model.sv
// Timing controller model that drives the serial load lines.
`timescale 1ns/100ps
`default_nettype none
module scd_ctrl_model (
  output logic sclk_out,
  output logic sdata_out,
  output logic load_n_out
);
  initial begin
    sclk_out = 1'b1;
    sdata_out = 1'b0;
    load_n_out = 1'b1;
  end
  // The clock idles high; data flips after the last bit's hold so stale bits never pass.
  // Serial clock and data edges sit at least 1.2 ns off the system clock edges; load enable moves on falling clock edges.
  task automatic send(input int n, input logic [15:0] word);
    load_n_out = 1'b0;
    #101.3;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out = 1'b0;
      sdata_out = word[i];
      #62.5;
      sclk_out = 1'b1;
      #62.5;
    end
    sdata_out = ~sdata_out;
    #(n % 2 == 1 ? 53.7 : 48.7);
    load_n_out = 1'b1;
    #100;
  endtask : send
  task automatic spin(input int n);
    #1.3;
    repeat (n) begin
      sclk_out = 1'b0;
      sdata_out = ~sdata_out;
      #62.5;
      sclk_out = 1'b1;
      #62.5;
    end
    #(n % 2 == 1 ? 53.7 : 48.7);
  endtask : spin
endmodule : scd_ctrl_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the serial control DAC loader.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic tst = 1'b0;
  logic [1:0] pmode = 2'h0;
  logic sclk;
  logic sdata;
  logic load_n;
  logic [7:0] dac_a;
  logic [7:0] dac_b;
  logic [1:0] mode;
  logic busy;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  initial forever #5 clk = ~clk;
  scd_loader DUT (.ref_clk_in(clk), .nrst_in(nrst), .serial_clk_in(sclk),
    .serial_data_in(sdata), .serial_load_enable_n_in(load_n),
    .test_force_normal_in(tst), .programmed_mode_in(pmode),
    .control_dac_out_a_out(dac_a), .control_dac_out_b_out(dac_b),
    .output_mode_out(mode), .busy_out(busy));
  scd_ctrl_model ctrl (.sclk_out(sclk), .sdata_out(sdata),
    .load_n_out(load_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // A hang is cut short well past the thousand or so cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic t_words();
    @(negedge clk);
    check(dac_a, 8'h00);
    fork
      ctrl.send(12, 16'h00A5);
      begin
        #150;
        check({7'h00, busy}, 8'h01);
      end
    join
    check(dac_a, 8'hA5);
    check(dac_b, 8'h00);
    check({7'h00, busy}, 8'h00);
    ctrl.send(12, 16'h0F3C);
    check(dac_b, 8'h3C);
    check(dac_a, 8'hA5);
    $display("test words done");
  endtask : t_words
  task automatic t_bad();
    ctrl.send(11, 16'h005A);
    check(dac_a, 8'hA5);
    check(dac_b, 8'h3C);
    ctrl.send(16, 16'hAF11);
    check(dac_a, 8'hA5);
    check(dac_b, 8'h3C);
    ctrl.spin(6);
    #100;
    check({7'h00, busy}, 8'h00);
    ctrl.send(12, 16'h0011);
    check(dac_a, 8'h11);
    $display("test bad done");
  endtask : t_bad
  task automatic t_reset();
    @(negedge clk);
    pmode = 2'h3;
    repeat (2) @(negedge clk);
    check({6'h00, mode}, 8'h03);
    nrst = 1'b0;
    @(negedge clk);
    check(dac_a, 8'h00);
    check(dac_b, 8'h00);
    check({6'h00, mode}, 8'h00);
    check({7'h00, busy}, 8'h00);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h00, busy}, 8'h00);
    check({6'h00, mode}, 8'h03);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mode();
    @(negedge clk);
    pmode = 2'h2;
    repeat (6) @(negedge clk);
    check({6'h00, mode}, 8'h02);
    tst = 1'b1;
    repeat (6) @(negedge clk);
    check({6'h00, mode}, 8'h00);
    pmode = 2'h1;
    repeat (6) @(negedge clk);
    check({6'h00, mode}, 8'h00);
    tst = 1'b0;
    repeat (6) @(negedge clk);
    check({6'h00, mode}, 8'h01);
    $display("test mode done");
  endtask : t_mode
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    t_words();
    t_bad();
    t_reset();
    t_mode();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
